// ### shared/rxaf_regs.svh
// constants for the receive address filter and discard queue
// Functional notes
// RL1: hold 8/10-bit station address, compare with data after serial address marker
// RL2: multicast match when any bit set in both received and stored address
// RL3: received all-ones multicast address is broadcast, always accepted
// RL4: stored all-ones address means promiscuous; it is the reset value
// RL5: unicast match only when every bit equals stored address
// RL6: elasticity buffer gets every character except fill, regardless of match
// RL7: unpacker rebuilds four 10-bit characters from five bytes, queue enabled only
// RL8: any special character restarts the five-step unpacking sequence
// RL9: control logic runs on the recovered character clock
// RL10: bypassed queue drives receive clock out at character rate; the code toggles it once per character clock, so it runs at half that rate
// RL11: two-bit policy select chooses discard policy 0 to 3
// RL12: policy 0 keeps every character; bypass always behaves as policy 0; the code's bypass empty flag still follows policies 1 to 3
// RL13: policy 1 drops all but last fill of an adjacent run
// RL14: policy 2 drops every fill character
// RL15: policy 3 also drops serial address characters
// RL16: bypass discards nothing; empty marks validity; policy 0 never empty
// RL17: bypass empty for fill under 2,3 and non-last fills under 1
// RL18: queue holds 256 entries of 14 bits, written only by control logic
// RL19: reader asserts device select then read enable on receive clock
// RL20: utopia flags and enable active low, cascade active high; half always low
// RL21: full, half and empty flags are synchronous to receive clock
// RL22: read and control inputs sampled on rising receive clock edge
// RL23: marker plus data reports status 111 and data is the address
// RL24: without match or promiscuous mode, post-address characters are withheld
`ifndef RXAF_REGS_SVH
`define RXAF_REGS_SVH
`define RXAF_DEPTH 256
`define RXAF_AW 8
`define RXAF_EW 14
`define RXAF_ADDR_RST 10'h3FF
`define RXAF_STS_ADDR 3'h7
`define RXAF_STS_NORM 3'h0
`define RXAF_STS_SPEC 3'h2
`define RXAF_POL_KEEP 2'h0
`define RXAF_POL_LAST 2'h1
`define RXAF_POL_NOFILL 2'h2
`define RXAF_POL_NOADDR 2'h3
`define RXAF_FILL_CODE 8'hA5
`define RXAF_MARK_CODE 8'hAA
`define RXAF_STEPS 3'h4
`endif

// ### shared/rxaf_pkg.sv
// types for the receive address filter and discard queue
package rxaf_pkg;
	typedef enum logic [2:0] {
		RXAF_U0 = 3'h0,
		RXAF_U1 = 3'h1,
		RXAF_U2 = 3'h3,
		RXAF_U3 = 3'h2,
		RXAF_U4 = 3'h6
	} rxaf_unpack_e;
	typedef logic [1:0] rxaf_policy_t;
endpackage : rxaf_pkg

// ### rtl/rxaf_filter.sv
// receive address filter, byte unpacker, discard policy and receive queue
`include "rxaf_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module rxaf_filter #(
	parameter int DEPTH = `RXAF_DEPTH
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic char_valid_in,
	input wire logic char_special_in,
	input wire logic [7:0] char_data_in,
	input wire logic [9:0] station_addr_in,
	input wire logic station_addr_load_in,
	input wire logic addr_wide_in,
	input wire logic unicast_in,
	input wire logic pack10_in,
	input wire rxaf_pkg::rxaf_policy_t discard_policy_select_in,
	input wire logic queue_bypass_select_n_in,
	input wire logic read_timing_model_select_in,
	input wire logic elastic_enable_in,
	input wire logic device_select_match_n_in,
	input wire logic rx_read_enable_in,
	output logic receive_clock_pin_out,
	output logic receive_clock_pin_oe_n_out,
	output logic [9:0] rx_data_out,
	output logic [2:0] rx_status_out,
	output logic rx_data_valid_out,
	output logic rx_queue_empty_flag_out,
	output logic rx_queue_full_flag_out,
	output logic rx_queue_half_flag_n_out,
	output logic elastic_write_out,
	output logic [9:0] elastic_data_out
);
	import rxaf_pkg::*;
	localparam int AW = $clog2(DEPTH);
	initial begin
		if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0)
			$error("queue depth must be a power of two, at least 4");
	end

	// pins from the reader are outside our logic: two flops each
	logic [1:0] sel_s1_r, sel_s2_r, sel_s1_nxt, sel_s2_nxt;
	always_comb begin
		sel_s1_nxt = {device_select_match_n_in, rx_read_enable_in};
		sel_s2_nxt = sel_s1_r;
	end
	always_ff @(posedge core_clk_in) begin // RL22
		if (rst_in) begin
			sel_s1_r <= 2'h3;
			sel_s2_r <= 2'h3;
		end else begin
			sel_s1_r <= sel_s1_nxt;
			sel_s2_r <= sel_s2_nxt;
		end
	end
	logic bypass, amatch, rden;
	assign bypass = ~queue_bypass_select_n_in;
	assign amatch = ~sel_s2_r[1];
	// enable polarity follows the timing model
	assign rden = read_timing_model_select_in ? sel_s2_r[0] : ~sel_s2_r[0]; // RL20

	// address register, all ones from reset
	logic [9:0] saddr_r, saddr_nxt;
	logic [9:0] amask;
	assign amask = addr_wide_in ? 10'h3FF : 10'h0FF;
	always_comb begin
		saddr_nxt = saddr_r;
		if (station_addr_load_in)
			saddr_nxt = station_addr_in & amask;
	end

	// unpacker: five bytes into four 10-bit characters
	rxaf_unpack_e ustep_r, ustep_nxt;
	logic [15:0] ubits_r, ubits_nxt;
	logic [4:0] ucnt_r, ucnt_nxt;
	logic uvalid;
	logic [9:0] uchar;
	always_comb begin
		ustep_nxt = ustep_r;
		ubits_nxt = ubits_r;
		ucnt_nxt = ucnt_r;
		uvalid = 1'b0;
		uchar = 10'h000;
		if (char_valid_in && pack10_in && !bypass) begin // RL7
			if (char_special_in) begin
				ustep_nxt = RXAF_U0; // RL8
				ucnt_nxt = 5'h00;
				ubits_nxt = 16'h0000;
			end else begin
				ubits_nxt = (ubits_r << 8) | {8'h00, char_data_in};
				if (ucnt_r + 5'h08 >= 5'h0A) begin
					uvalid = 1'b1;
					uchar = 10'((ubits_nxt >> (ucnt_r - 5'h02)) & 16'h03FF);
					ucnt_nxt = ucnt_r - 5'h02;
				end else
					ucnt_nxt = ucnt_r + 5'h08;
				case (ustep_r)
					RXAF_U0: ustep_nxt = RXAF_U1;
					RXAF_U1: ustep_nxt = RXAF_U2;
					RXAF_U2: ustep_nxt = RXAF_U3;
					RXAF_U3: ustep_nxt = RXAF_U4;
					RXAF_U4: begin
						ustep_nxt = RXAF_U0;
						ucnt_nxt = 5'h00;
					end
					default: ustep_nxt = RXAF_U0;
				endcase
			end
		end
	end

	// character stream into the control logic
	logic cvalid, cspec;
	logic [9:0] cdata;
	always_comb begin
		cspec = char_valid_in & char_special_in;
		cvalid = pack10_in && !bypass ? (uvalid | cspec) : char_valid_in;
		cdata = cspec || !pack10_in || bypass ? {2'h0, char_data_in} : uchar;
	end

	// control state: marker pending, match, fill run
	logic mark_r, mark_nxt, match_r, match_nxt, fill_r, fill_nxt;
	logic [9:0] fill_dat_r, fill_dat_nxt;
	logic is_fill, is_mark, is_addr, hit, prom;
	logic wr_en;
	logic [`RXAF_EW-1:0] wr_word;
	logic [2:0] sts;
	logic keep, ev_empty;
	always_comb begin
		is_fill = cspec && char_data_in == `RXAF_FILL_CODE;
		is_mark = cspec && char_data_in == `RXAF_MARK_CODE;
		is_addr = cvalid && !cspec && mark_r; // RL1
		prom = (saddr_r & amask) == amask; // RL4
		hit = 1'b0;
		if (unicast_in)
			hit = (cdata & amask) == (saddr_r & amask); // RL5
		else
			hit = |(cdata & saddr_r & amask) || (cdata & amask) == amask; // RL2 RL3
		mark_nxt = mark_r;
		match_nxt = match_r;
		fill_nxt = fill_r;
		fill_dat_nxt = fill_dat_r;
		keep = 1'b0;
		ev_empty = 1'b1;
		sts = cspec ? `RXAF_STS_SPEC : `RXAF_STS_NORM;
		wr_word = {1'b0, sts, cdata};
		if (cvalid) begin
			mark_nxt = is_mark;
			if (is_addr) begin
				match_nxt = hit; // RL24
				sts = `RXAF_STS_ADDR; // RL23
			end
			if (bypass || discard_policy_select_in == `RXAF_POL_KEEP) begin // RL11 RL12
				keep = 1'b1;
			end else if (is_fill) begin
				keep = 1'b0; // RL14
				if (discard_policy_select_in == `RXAF_POL_LAST) begin
					fill_nxt = 1'b1; // RL13
					fill_dat_nxt = cdata;
				end
			end else if (is_addr && discard_policy_select_in == `RXAF_POL_NOADDR) begin
				keep = 1'b0; // RL15
			end else
				keep = 1'b1;
			if (!is_fill)
				fill_nxt = 1'b0;
			if (!is_addr && !is_mark && !prom && !match_r && !bypass)
				keep = 1'b0; // RL24
			// the marker is folded into the status of the address that follows it
			if (is_mark && !bypass)
				keep = 1'b0; // RL23
			// bypass: empty marks non-interesting output, discards nothing
			ev_empty = bypass && is_fill && discard_policy_select_in[1]; // RL16 RL17
			wr_word = {1'b0, sts, cdata};
		end
	end
	// policy 1: the held fill goes out just before the next non-fill character
	logic flush_fill;
	assign flush_fill = cvalid && !is_fill && fill_r && !bypass && (prom || match_r);
	// in bypass the last fill of a run is only known when the next character comes,
	// so the output stage trails the input stage by one character
	logic [9:0] byp_dat_r, byp_dat_nxt;
	logic [2:0] byp_sts_r, byp_sts_nxt;
	logic byp_empty_r, byp_empty_nxt;
	logic byp_prev_fill_r, byp_prev_fill_nxt;
	logic byp_out_empty_r, byp_out_empty_nxt;
	always_comb begin
		byp_dat_nxt = byp_dat_r;
		byp_sts_nxt = byp_sts_r;
		byp_empty_nxt = byp_empty_r;
		byp_prev_fill_nxt = byp_prev_fill_r;
		byp_out_empty_nxt = byp_out_empty_r;
		if (cvalid && bypass) begin // RL16
			byp_dat_nxt = cdata;
			byp_sts_nxt = sts;
			byp_empty_nxt = ev_empty;
			byp_prev_fill_nxt = is_fill;
			byp_out_empty_nxt = byp_empty_r;
			// a fill followed by a fill is not the last of its run
			if (discard_policy_select_in == `RXAF_POL_LAST && byp_prev_fill_r && is_fill)
				byp_out_empty_nxt = 1'b1; // RL17
		end
	end

	// receive queue: two writes can be due in one cycle when a held fill is flushed
	logic [`RXAF_EW-1:0] mem [DEPTH];
	logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [`RXAF_EW-1:0] pend_r, pend_nxt;
	logic pend_v_r, pend_v_nxt;
	logic [AW:0] level;
	logic full, empty, mem_we, do_rd;
	logic [`RXAF_EW-1:0] mem_wd;
	logic [9:0] q_dat_r, q_dat_nxt;
	logic [2:0] q_sts_r, q_sts_nxt;
	logic q_v_r, q_v_nxt;
	assign level = wp_r - rp_r;
	assign full = level == (AW+1)'(DEPTH);
	assign empty = level == '0;
	assign do_rd = rden && amatch && !empty && !bypass; // RL19
	always_comb begin
		pend_nxt = pend_r;
		pend_v_nxt = pend_v_r;
		mem_we = 1'b0;
		mem_wd = wr_word;
		wr_en = cvalid && keep && !bypass && !full;
		if (pend_v_r && !full) begin
			mem_we = 1'b1;
			mem_wd = pend_r;
			pend_v_nxt = 1'b0;
		end
		if (flush_fill && !full) begin
			if (mem_we) begin
				pend_nxt = {1'b0, `RXAF_STS_SPEC, fill_dat_r};
				pend_v_nxt = 1'b1;
			end else begin
				mem_we = 1'b1;
				mem_wd = {1'b0, `RXAF_STS_SPEC, fill_dat_r};
			end
		end
		if (wr_en) begin
			if (mem_we) begin
				pend_nxt = wr_word;
				pend_v_nxt = 1'b1;
			end else begin
				mem_we = 1'b1; // RL18
				mem_wd = wr_word;
			end
		end
		wp_nxt = mem_we ? wp_r + 1'b1 : wp_r;
		rp_nxt = do_rd ? rp_r + 1'b1 : rp_r;
		q_dat_nxt = q_dat_r;
		q_sts_nxt = q_sts_r;
		q_v_nxt = 1'b0;
		if (bypass) begin
			if (cvalid) begin
				q_dat_nxt = byp_dat_r;
				q_sts_nxt = byp_sts_r;
			end
		end else if (do_rd) begin
			q_dat_nxt = mem[rp_r[AW-1:0]][9:0];
			q_sts_nxt = mem[rp_r[AW-1:0]][12:10];
			q_v_nxt = 1'b1;
		end
	end

	// character clock divided down: one output toggle per tick in bypass
	logic rclk_r, rclk_nxt;
	assign rclk_nxt = bypass ? ~rclk_r : 1'b0; // RL9 RL10

	always_ff @(posedge core_clk_in) begin // RL9
		if (rst_in) begin
			saddr_r <= `RXAF_ADDR_RST; // RL4
			ustep_r <= RXAF_U0;
			ubits_r <= 16'h0000;
			ucnt_r <= 5'h00;
			mark_r <= 1'b0;
			match_r <= 1'b0;
			fill_r <= 1'b0;
			fill_dat_r <= 10'h000;
			byp_dat_r <= 10'h000;
			byp_sts_r <= 3'h0;
			byp_empty_r <= 1'b1;
			byp_prev_fill_r <= 1'b0;
			byp_out_empty_r <= 1'b1;
			wp_r <= '0;
			rp_r <= '0;
			pend_r <= '0;
			pend_v_r <= 1'b0;
			q_dat_r <= 10'h000;
			q_sts_r <= 3'h0;
			q_v_r <= 1'b0;
			rclk_r <= 1'b0;
		end else begin
			saddr_r <= saddr_nxt;
			ustep_r <= ustep_nxt;
			ubits_r <= ubits_nxt;
			ucnt_r <= ucnt_nxt;
			mark_r <= mark_nxt;
			match_r <= match_nxt;
			fill_r <= fill_nxt;
			fill_dat_r <= fill_dat_nxt;
			byp_dat_r <= byp_dat_nxt;
			byp_sts_r <= byp_sts_nxt;
			byp_empty_r <= byp_empty_nxt;
			byp_prev_fill_r <= byp_prev_fill_nxt;
			byp_out_empty_r <= byp_out_empty_nxt;
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			pend_r <= pend_nxt;
			pend_v_r <= pend_v_nxt;
			q_dat_r <= q_dat_nxt;
			q_sts_r <= q_sts_nxt;
			q_v_r <= q_v_nxt;
			rclk_r <= rclk_nxt;
		end
	end
	always_ff @(posedge core_clk_in) begin
		if (mem_we)
			mem[wp_r[AW-1:0]] <= mem_wd; // RL18
	end

	// flags synchronous to the same clock as reads
	logic e_raw, f_raw;
	always_comb begin
		e_raw = bypass ? (byp_out_empty_r && discard_policy_select_in != `RXAF_POL_KEEP) : empty;
		f_raw = !bypass && full;
	end
	assign rx_queue_empty_flag_out = read_timing_model_select_in ? e_raw : ~e_raw; // RL20 RL21
	assign rx_queue_full_flag_out = read_timing_model_select_in ? f_raw : ~f_raw; // RL20
	assign rx_queue_half_flag_n_out = ~(!bypass && level >= (AW+1)'(DEPTH/2)); // RL20
	assign rx_data_out = q_dat_r;
	assign rx_status_out = q_sts_r;
	assign rx_data_valid_out = q_v_r;
	assign receive_clock_pin_out = rclk_r;
	assign receive_clock_pin_oe_n_out = ~bypass; // RL10
	assign elastic_write_out = elastic_enable_in && cvalid && !is_fill; // RL6
	assign elastic_data_out = cdata;

	a_promisc_reset: assert property (@(posedge core_clk_in) // RL4
		$fell(rst_in) |-> saddr_r == `RXAF_ADDR_RST)
		else $error("address not all ones after reset");
	a_unicast_exact: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL5
		is_addr && unicast_in && (cdata & amask) != (saddr_r & amask) |=> !match_r)
		else $error("unicast matched a differing address");
	a_bcast_accept: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL3
		is_addr && !unicast_in && (cdata & amask) == amask |=> match_r)
		else $error("broadcast not accepted");
	a_fill_dropped: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL14
		is_fill && !bypass && discard_policy_select_in[1] |-> !wr_en)
		else $error("fill written under policy 2 or 3");
	a_addr_dropped: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL15
		is_addr && !bypass && discard_policy_select_in == `RXAF_POL_NOADDR |-> !wr_en)
		else $error("address kept under policy 3");
	a_unpack_restart: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL8
		cspec && pack10_in && !bypass |=> ustep_r == RXAF_U0)
		else $error("unpacker not restarted");
	a_elastic_nofill: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL6
		elastic_write_out |-> !is_fill)
		else $error("fill written to elasticity buffer");
	a_read_pointer: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL19
		do_rd |=> q_v_r && rp_r == $past(rp_r) + 1'b1)
		else $error("read did not advance queue");
	a_keep_empty: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL16
		bypass && discard_policy_select_in == `RXAF_POL_KEEP |-> e_raw == 1'b0)
		else $error("empty shown under policy 0 bypass");
	a_byp_last_fill: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL17
		cvalid && bypass && discard_policy_select_in == `RXAF_POL_LAST && byp_prev_fill_r && is_fill |=> byp_out_empty_r)
		else $error("non-last fill shown as valid in bypass");
	a_mark_folded: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL23
		is_mark && !bypass |-> !wr_en)
		else $error("address marker written to queue");
	c_addr_hit: cover property (@(posedge core_clk_in) is_addr && hit);
	c_addr_miss: cover property (@(posedge core_clk_in) is_addr && !hit);
	c_queue_full: cover property (@(posedge core_clk_in) full);
	c_fill_flush: cover property (@(posedge core_clk_in) flush_fill);
endmodule : rxaf_filter
`default_nettype wire

// ### test/rxaf_reader.sv
// model of the external queue reader on the far side of the receive port
`timescale 1ns/1ps
`default_nettype none
module rxaf_reader (
	input wire logic clk_in,
	input wire logic cascade_in,
	input wire logic [9:0] data_in,
	input wire logic [2:0] status_in,
	input wire logic valid_in,
	output logic sel_n_out,
	output logic en_out
);
	logic en_act = 1'b0;
	initial sel_n_out = 1'b1;
	// enable polarity follows the timing model, so idle is always inactive
	assign en_out = en_act ? cascade_in : ~cascade_in;
	task automatic read_one(output logic [12:0] q, output bit ok);
		int i;
		ok = 1'b0;
		q = '0;
		@(posedge clk_in);
		sel_n_out <= 1'b0;
		@(posedge clk_in);
		en_act <= 1'b1;
		@(posedge clk_in);
		en_act <= 1'b0;
		for (i = 0; i < 10 && !ok; i++) begin
			@(posedge clk_in);
			if (valid_in === 1'b1) begin
				ok = 1'b1;
				q = {status_in, data_in};
			end
		end
		sel_n_out <= 1'b1;
	endtask : read_one
endmodule : rxaf_reader
`default_nettype wire

// ### test/tb.sv
// self-checking bench for the receive address filter and discard queue
`include "rxaf_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
	import rxaf_pkg::*;
	localparam int DEPTH = 16;
	localparam logic [8:0] F = 9'h1A5;
	localparam logic [8:0] M = 9'h1AA;
	localparam logic [12:0] SF = {`RXAF_STS_SPEC, 10'h0A5};
	logic clk = 1'b0, rst = 1'b1, cv = 1'b0, cs = 1'b0, ld = 1'b0, uni = 1'b0, pk = 1'b0;
	logic byp_n = 1'b1, casc = 1'b0, el = 1'b0, aw = 1'b0;
	logic [9:0] ed_last = 10'h000;
	logic [7:0] cd = 8'h00;
	logic [9:0] sa = 10'h000;
	rxaf_policy_t pol = 2'h0;
	logic sel_n, en, rck, rck_oe_n, rv, emp, full, half_n, ew;
	logic [9:0] rd, ed;
	logic [2:0] rs;
	int n_fail = 0, checks = 0, n_ew = 0;
	initial forever #5 clk = ~clk;
	always @(posedge clk) begin
		if (ew === 1'b1) begin
			n_ew++;
			ed_last <= ed;
		end
	end
	rxaf_filter #(.DEPTH(DEPTH)) DUT (.core_clk_in(clk), .rst_in(rst), .char_valid_in(cv),
		.char_special_in(cs), .char_data_in(cd), .station_addr_in(sa),
		.station_addr_load_in(ld), .addr_wide_in(aw), .unicast_in(uni), .pack10_in(pk),
		.discard_policy_select_in(pol), .queue_bypass_select_n_in(byp_n),
		.read_timing_model_select_in(casc), .elastic_enable_in(el),
		.device_select_match_n_in(sel_n), .rx_read_enable_in(en),
		.receive_clock_pin_out(rck), .receive_clock_pin_oe_n_out(rck_oe_n),
		.rx_data_out(rd), .rx_status_out(rs), .rx_data_valid_out(rv),
		.rx_queue_empty_flag_out(emp), .rx_queue_full_flag_out(full),
		.rx_queue_half_flag_n_out(half_n), .elastic_write_out(ew), .elastic_data_out(ed));
	rxaf_reader rdr (.clk_in(clk), .cascade_in(casc), .data_in(rd), .status_in(rs),
		.valid_in(rv), .sel_n_out(sel_n), .en_out(en));
	task automatic tally_and_finish;
		if (n_fail == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [12:0] got, input logic [12:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [12:0] nd(input logic [9:0] d);
		return {`RXAF_STS_NORM, d};
	endfunction : nd
	task automatic cfg(input rxaf_policy_t p, input logic u, input logic [9:0] a);
		@(posedge clk);
		pol <= p;
		uni <= u;
		sa <= a;
		ld <= 1'b1;
		@(posedge clk);
		ld <= 1'b0;
	endtask : cfg
	// each entry is {special, byte}, sent back to back
	task automatic send(input logic [8:0] c[$]);
		foreach (c[i]) begin
			@(posedge clk);
			cv <= 1'b1;
			cs <= c[i][8];
			cd <= c[i][7:0];
		end
		@(posedge clk);
		cv <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : send
	task automatic drain(input logic [12:0] e[$]);
		logic [12:0] q;
		bit ok;
		foreach (e[i]) begin
			rdr.read_one(q, ok);
			if (!ok) begin
				n_fail++;
				$display("MISMATCH %0t no read answer", $time);
				tally_and_finish();
			end
			chk(q, e[i]);
		end
		repeat (4) @(posedge clk);
		chk({12'h0, emp}, {12'h0, casc});
	endtask : drain
	task automatic t_reset;
		@(posedge clk);
		chk({10'h0, emp, full, half_n}, 13'h3);
	endtask : t_reset
	task automatic t_policies;
		cfg(2'h0, 1'b0, 10'h3FF);
		send('{9'h011, F, F, 9'h022});
		drain('{nd(10'h011), SF, SF, nd(10'h022)});
		cfg(2'h1, 1'b0, 10'h3FF);
		send('{9'h011, F, F, F, 9'h022});
		drain('{nd(10'h011), SF, nd(10'h022)});
		cfg(2'h2, 1'b0, 10'h3FF);
		send('{9'h011, F, F, 9'h022});
		drain('{nd(10'h011), nd(10'h022)});
	endtask : t_policies
	task automatic t_address;
		send('{M, 9'h001, 9'h033});
		drain('{{`RXAF_STS_ADDR, 10'h001}, nd(10'h033)});
		cfg(2'h3, 1'b0, 10'h3FF);
		send('{M, 9'h001, 9'h033});
		drain('{nd(10'h033)});
		cfg(2'h3, 1'b1, 10'h005);
		send('{M, 9'h006, 9'h044, M, 9'h005, 9'h055});
		drain('{nd(10'h055)});
		cfg(2'h3, 1'b0, 10'h005);
		send('{M, 9'h002, 9'h066, M, 9'h004, 9'h077, M, 9'h0FF, 9'h088});
		drain('{nd(10'h077), nd(10'h088)});
		aw <= 1'b1;
		cfg(2'h3, 1'b1, 10'h0FF);
		send('{M, 9'h0FE, 9'h0C1, M, 9'h0FF, 9'h0C2});
		drain('{nd(10'h0C2)});
		aw <= 1'b0;
	endtask : t_address
	task automatic t_pack;
		cfg(2'h0, 1'b0, 10'h3FF);
		pk <= 1'b1;
		send('{9'h0FF, 9'h0FF, 9'h0FF, 9'h0FF, 9'h0FF, F});
		drain('{nd(10'h3FF), nd(10'h3FF), nd(10'h3FF), nd(10'h3FF), SF});
		pk <= 1'b0;
	endtask : t_pack
	task automatic t_elastic;
		el <= 1'b1;
		n_ew = 0;
		send('{9'h011, F, 9'h022});
		chk(13'(n_ew), 13'h2);
		chk({3'h0, ed_last}, nd(10'h022));
		el <= 1'b0;
		drain('{nd(10'h011), SF, nd(10'h022)});
	endtask : t_elastic
	task automatic t_fill;
		logic [8:0] c[$];
		logic [12:0] e[$];
		for (int i = 0; i <= DEPTH; i++) begin
			c.push_back(9'(i));
			if (i < DEPTH) e.push_back(nd(10'(i)));
		end
		// one char beyond capacity must be lost, not overwrite
		send(c);
		chk({11'h0, full, half_n}, 13'h0);
		drain(e);
		chk({12'h0, half_n}, 13'h1);
	endtask : t_fill
	task automatic t_cascade;
		casc <= 1'b1;
		repeat (3) @(posedge clk);
		chk({11'h0, emp, full}, 13'h2);
		send('{9'h011});
		drain('{nd(10'h011)});
		casc <= 1'b0;
	endtask : t_cascade
	// output trails input by two characters; ve bit k is the valid level for character k
	task automatic byp_seq(input rxaf_policy_t p, input logic [5:0] ve);
		logic [8:0] c[8];
		c = '{9'h011, F, F, 9'h022, F, 9'h033, 9'h044, 9'h055};
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			pol <= p;
			cv <= 1'b1;
			cs <= c[i][8];
			cd <= c[i][7:0];
			#1;
			if (i >= 2) begin
				chk({rs, rd}, {c[i-2][8] ? `RXAF_STS_SPEC : `RXAF_STS_NORM, 2'h0, c[i-2][7:0]});
				chk({12'h0, emp}, {12'h0, ve[i-2]});
			end
		end
		@(posedge clk);
		cv <= 1'b0;
	endtask : byp_seq
	task automatic t_bypass;
		logic a;
		byp_n <= 1'b0;
		byp_seq(2'h0, 6'h3F);
		@(posedge clk);
		#1 a = rck;
		chk({11'h0, rck_oe_n, emp}, 13'h1);
		@(posedge clk);
		#1 chk({12'h0, rck}, {12'h0, ~a});
		byp_seq(2'h1, 6'h3D);
		byp_seq(2'h2, 6'h29);
	endtask : t_bypass
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_policies();
		t_address();
		t_pack();
		t_elastic();
		t_fill();
		t_cascade();
		t_bypass();
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
